// ===== jtc_tap.sv
// test access port: controller, instruction register, data register select and tdo
// assumes tck, tms, tdi, fuse, disable and boundary pins are asynchronous to the core clock
`timescale 1ns/1ps
`include "jtc_regs.svh"

module jtc_tap #(
   parameter logic [`JTC_ID_W-1:0] ID_CODE = 32'h1234_5001 // arbitrary identity value
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire jtc_pkg::jtc_pins_t i_pins,
   input wire logic i_test_port_enable_fuse,
   input wire logic i_test_port_disable_bit,
   input wire logic i_ocd_enable,
   input wire logic [`JTC_BSCAN_W-1:0] i_bscan_in,
   input wire logic [`JTC_PROG_W-1:0] i_prog_in,
   input wire logic [`JTC_ISC_W-1:0] i_isc_in,
   input wire logic [`JTC_BPC_W-1:0] i_bpc_in,
   output logic o_tdo,
   output logic o_tdo_oe,
   output logic o_pullup_en,
   output logic o_port_mode,
   output logic o_run_idle,
   output logic o_extest,
   output logic [`JTC_IR_W-1:0] o_instr,
   output logic [`JTC_BSCAN_W-1:0] o_bscan_out,
   output logic [`JTC_PROG_W-1:0] o_prog_out,
   output logic [`JTC_ISC_W-1:0] o_isc_out,
   output logic [`JTC_BPC_W-1:0] o_bpc_out
);

   localparam int SW = `JTC_CTRL_SYNC_W + `JTC_BSCAN_W;

   // next controller state from tms
   function automatic jtc_pkg::jtc_state_t next_state(input jtc_pkg::jtc_state_t st, input logic tms);
      jtc_pkg::jtc_state_t nx;
      nx = jtc_pkg::st_tlr;
      case (st)
         jtc_pkg::st_tlr: nx = tms ? jtc_pkg::st_tlr : jtc_pkg::st_rti;
         jtc_pkg::st_rti: nx = tms ? jtc_pkg::st_sel_dr : jtc_pkg::st_rti;
         jtc_pkg::st_sel_dr: nx = tms ? jtc_pkg::st_sel_ir : jtc_pkg::st_cap_dr;
         jtc_pkg::st_cap_dr: nx = tms ? jtc_pkg::st_exit1_dr : jtc_pkg::st_shift_dr;
         jtc_pkg::st_shift_dr: nx = tms ? jtc_pkg::st_exit1_dr : jtc_pkg::st_shift_dr;
         jtc_pkg::st_exit1_dr: nx = tms ? jtc_pkg::st_upd_dr : jtc_pkg::st_pause_dr;
         jtc_pkg::st_pause_dr: nx = tms ? jtc_pkg::st_exit2_dr : jtc_pkg::st_pause_dr;
         jtc_pkg::st_exit2_dr: nx = tms ? jtc_pkg::st_upd_dr : jtc_pkg::st_shift_dr;
         jtc_pkg::st_upd_dr: nx = tms ? jtc_pkg::st_sel_dr : jtc_pkg::st_rti;
         jtc_pkg::st_sel_ir: nx = tms ? jtc_pkg::st_tlr : jtc_pkg::st_cap_ir;
         jtc_pkg::st_cap_ir: nx = tms ? jtc_pkg::st_exit1_ir : jtc_pkg::st_shift_ir;
         jtc_pkg::st_shift_ir: nx = tms ? jtc_pkg::st_exit1_ir : jtc_pkg::st_shift_ir;
         jtc_pkg::st_exit1_ir: nx = tms ? jtc_pkg::st_upd_ir : jtc_pkg::st_pause_ir;
         jtc_pkg::st_pause_ir: nx = tms ? jtc_pkg::st_exit2_ir : jtc_pkg::st_pause_ir;
         jtc_pkg::st_exit2_ir: nx = tms ? jtc_pkg::st_upd_ir : jtc_pkg::st_shift_ir;
         jtc_pkg::st_upd_ir: nx = tms ? jtc_pkg::st_sel_dr : jtc_pkg::st_rti;
         default: nx = jtc_pkg::st_tlr;
      endcase
      return nx;
   endfunction : next_state

   // instruction to data register; debug chains fall back to bypass when debug is off
   function automatic jtc_pkg::jtc_dr_t decode_dr(input logic [`JTC_IR_W-1:0] ins, input logic ocd);
      jtc_pkg::jtc_dr_t sel;
      sel = jtc_pkg::dr_bypass;
      case (ins)
         `JTC_INS_EXTEST: sel = jtc_pkg::dr_bscan;
         `JTC_INS_SAMPLE: sel = jtc_pkg::dr_bscan;
         `JTC_INS_IDCODE: sel = jtc_pkg::dr_idcode;
         `JTC_INS_PROG: sel = jtc_pkg::dr_prog;
         `JTC_INS_DBG_ISC: sel = ocd ? jtc_pkg::dr_isc : jtc_pkg::dr_bypass;
         `JTC_INS_DBG_BPC: sel = ocd ? jtc_pkg::dr_bpc : jtc_pkg::dr_bypass;
         default: sel = jtc_pkg::dr_bypass;
      endcase
      return sel;
   endfunction : decode_dr

   logic [SW-1:0] async_vec;
   logic [SW-1:0] sync_vec;
   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic fuse_s;
   logic dis_s;
   logic ocd_s;
   logic [`JTC_BSCAN_W-1:0] bscan_s;
   logic tck_d_reg;
   logic tck_rise;
   logic tck_fall;
   logic port_en;
   jtc_pkg::jtc_state_t state_reg;
   logic [2:0] ones_reg;
   logic [`JTC_IR_W-1:0] ir_shift_reg;
   logic bypass_reg;
   logic [`JTC_ID_W-1:0] id_shift_reg;
   jtc_pkg::jtc_dr_t dr_sel;
   jtc_pkg::jtc_strobe_t dr_stb;
   jtc_pkg::jtc_strobe_t bscan_stb;
   jtc_pkg::jtc_strobe_t prog_stb;
   jtc_pkg::jtc_strobe_t isc_stb;
   jtc_pkg::jtc_strobe_t bpc_stb;
   logic bscan_tdo;
   logic prog_tdo;
   logic isc_tdo;
   logic bpc_tdo;
   logic tdo_next;

   // every pin-side level passes two flip-flops
   assign async_vec = {i_bscan_in, i_pins.tck, i_pins.tms, i_pins.tdi,
                       i_test_port_enable_fuse, i_test_port_disable_bit, i_ocd_enable};

   jtc_sync #(
      .W(SW)
   ) u_sync (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_async(async_vec),
      .o_sync(sync_vec)
   );

   assign bscan_s = sync_vec[SW-1:`JTC_CTRL_SYNC_W];
   assign tck_s = sync_vec[5];
   assign tms_s = sync_vec[4];
   assign tdi_s = sync_vec[3];
   assign fuse_s = sync_vec[2];
   assign dis_s = sync_vec[1];
   assign ocd_s = sync_vec[0];

   // tck edge finder on the synchronised level
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         tck_d_reg <= 1'b0;
      else
         tck_d_reg <= tck_s;
   end

   assign tck_rise = tck_s & ~tck_d_reg;
   assign tck_fall = ~tck_s & tck_d_reg;
   assign port_en = fuse_s & ~dis_s;

   // controller: power-on reset or a disabled port hold test-logic-reset
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         state_reg <= jtc_pkg::st_tlr;
      else if (!port_en)
         state_reg <= jtc_pkg::st_tlr;
      else if (tck_rise)
         state_reg <= next_state(state_reg, tms_s);
   end

   // run of consecutive tms-high edges, watched by the reset check
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         ones_reg <= 3'h0;
      else if (!port_en)
         ones_reg <= 3'h0;
      else if (tck_rise)
         ones_reg <= !tms_s ? 3'h0 : (ones_reg == `JTC_TLR_ONES) ? ones_reg : ones_reg + 3'h1;
   end

   // instruction shift path: capture 0x01, shift lsb first
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         ir_shift_reg <= `JTC_IR_CAPTURE;
      else if (tck_rise && state_reg == jtc_pkg::st_cap_ir)
         ir_shift_reg <= `JTC_IR_CAPTURE;
      else if (tck_rise && state_reg == jtc_pkg::st_shift_ir)
         ir_shift_reg <= {tdi_s, ir_shift_reg[`JTC_IR_W-1:1]};
   end

   // active instruction: identification after reset, new code only in update-ir
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_instr <= `JTC_INS_IDCODE;
      else if (state_reg == jtc_pkg::st_tlr)
         o_instr <= `JTC_INS_IDCODE;
      else if (tck_rise && state_reg == jtc_pkg::st_upd_ir)
         o_instr <= ir_shift_reg;
   end

   assign dr_sel = decode_dr(o_instr, ocd_s);

   // data strobes; exit, pause and exit2 states raise none
   assign dr_stb.capture = tck_rise && state_reg == jtc_pkg::st_cap_dr;
   assign dr_stb.shift = tck_rise && state_reg == jtc_pkg::st_shift_dr;
   assign dr_stb.update = tck_rise && state_reg == jtc_pkg::st_upd_dr;
   assign bscan_stb = (dr_sel == jtc_pkg::dr_bscan) ? dr_stb : 3'h0;
   assign prog_stb = (dr_sel == jtc_pkg::dr_prog) ? dr_stb : 3'h0;
   assign isc_stb = (dr_sel == jtc_pkg::dr_isc) ? dr_stb : 3'h0;
   assign bpc_stb = (dr_sel == jtc_pkg::dr_bpc) ? dr_stb : 3'h0;

   // bypass cell captures zero
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         bypass_reg <= 1'b0;
      else if (dr_sel == jtc_pkg::dr_bypass && dr_stb.capture)
         bypass_reg <= 1'b0;
      else if (dr_sel == jtc_pkg::dr_bypass && dr_stb.shift)
         bypass_reg <= tdi_s;
   end

   // identification register captures the fixed code
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         id_shift_reg <= '0;
      else if (dr_sel == jtc_pkg::dr_idcode && dr_stb.capture)
         id_shift_reg <= ID_CODE;
      else if (dr_sel == jtc_pkg::dr_idcode && dr_stb.shift)
         id_shift_reg <= {tdi_s, id_shift_reg[`JTC_ID_W-1:1]};
   end

   jtc_data_reg #(
      .W(`JTC_BSCAN_W)
   ) u_bscan (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_strobe(bscan_stb),
      .i_tdi(tdi_s),
      .i_par_in(bscan_s),
      .o_par_out(o_bscan_out),
      .o_tdo(bscan_tdo)
   );

   jtc_data_reg #(
      .W(`JTC_PROG_W)
   ) u_prog (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_strobe(prog_stb),
      .i_tdi(tdi_s),
      .i_par_in(i_prog_in),
      .o_par_out(o_prog_out),
      .o_tdo(prog_tdo)
   );

   jtc_data_reg #(
      .W(`JTC_ISC_W)
   ) u_isc (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_strobe(isc_stb),
      .i_tdi(tdi_s),
      .i_par_in(i_isc_in),
      .o_par_out(o_isc_out),
      .o_tdo(isc_tdo)
   );

   jtc_data_reg #(
      .W(`JTC_BPC_W)
   ) u_bpc (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_strobe(bpc_stb),
      .i_tdi(tdi_s),
      .i_par_in(i_bpc_in),
      .o_par_out(o_bpc_out),
      .o_tdo(bpc_tdo)
   );

   // serial output select: instruction path or the chosen data register
   always_comb
   begin
      tdo_next = bypass_reg;
      if (state_reg == jtc_pkg::st_shift_ir)
         tdo_next = ir_shift_reg[0];
      else
      begin
         case (dr_sel)
            jtc_pkg::dr_idcode: tdo_next = id_shift_reg[0];
            jtc_pkg::dr_bscan: tdo_next = bscan_tdo;
            jtc_pkg::dr_prog: tdo_next = prog_tdo;
            jtc_pkg::dr_isc: tdo_next = isc_tdo;
            jtc_pkg::dr_bpc: tdo_next = bpc_tdo;
            default: tdo_next = bypass_reg;
         endcase
      end
   end

   // tdo and its enable move on falling tck; a disabled port drops the enable at once
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_tdo <= 1'b0;
         o_tdo_oe <= 1'b0;
      end
      else if (!port_en)
         o_tdo_oe <= 1'b0;
      else if (tck_fall)
      begin
         o_tdo <= tdo_next;
         o_tdo_oe <= state_reg == jtc_pkg::st_shift_ir || state_reg == jtc_pkg::st_shift_dr;
      end
   end

   // pin mode, pull-ups and instruction side effects
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_pullup_en <= 1'b0;
         o_port_mode <= 1'b1;
         o_run_idle <= 1'b0;
         o_extest <= 1'b0;
      end
      else
      begin
         o_pullup_en <= port_en;
         o_port_mode <= ~port_en;
         o_run_idle <= port_en && state_reg == jtc_pkg::st_rti;
         o_extest <= port_en && o_instr == `JTC_INS_EXTEST;
      end
   end

   a_idle_to_select:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (tck_rise && port_en && state_reg == jtc_pkg::st_rti && tms_s) |=> state_reg == jtc_pkg::st_sel_dr)
      else $error("idle with tms high did not reach select-dr");

   a_disabled_holds_reset:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      !port_en |=> state_reg == jtc_pkg::st_tlr && o_port_mode)
      else $error("disabled port not held in reset");

   a_ir_capture_value:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (tck_rise && port_en && state_reg == jtc_pkg::st_cap_ir) |=> ir_shift_reg == `JTC_IR_CAPTURE)
      else $error("capture-ir did not load 0x01");

   a_ir_lsb_first:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (tck_rise && port_en && state_reg == jtc_pkg::st_shift_ir)
      |=> ir_shift_reg[`JTC_IR_W-1] == $past(tdi_s) && ir_shift_reg[0] == $past(ir_shift_reg[1]))
      else $error("instruction shift not lsb first");

   a_instr_update_only:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      !$stable(o_instr) |-> $past(state_reg) == jtc_pkg::st_upd_ir || $past(state_reg) == jtc_pkg::st_tlr)
      else $error("instruction changed outside update-ir");

   a_five_ones_reset:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (tck_rise && port_en && tms_s && ones_reg == 3'h4) |=> state_reg == jtc_pkg::st_tlr)
      else $error("five tms-high edges did not reach test-logic-reset");

   a_tdo_on_fall:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      ($rose(o_tdo_oe) || !$stable(o_tdo)) |-> $past(tck_fall))
      else $error("tdo moved away from a falling tck");

   a_tdo_idle_off:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      (tck_fall && port_en && state_reg == jtc_pkg::st_rti) |=> !o_tdo_oe)
      else $error("tdo driven outside shift states");

   a_pullup_follow:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      port_en [*2] |-> o_pullup_en && !o_port_mode)
      else $error("enabled port lacks pull-ups");

endmodule : jtc_tap

// ===== jtc_regs.svh
// constants of the test access port: instruction codes, widths, counts
// assumes inclusion by jtc_pkg and by the design modules that need the numbers
`ifndef JTC_REGS_SVH
`define JTC_REGS_SVH

// instruction register
`define JTC_IR_W 4
`define JTC_IR_CAPTURE 4'h1
`define JTC_INS_EXTEST 4'h0
`define JTC_INS_IDCODE 4'h1
`define JTC_INS_SAMPLE 4'h2
`define JTC_INS_PROG 4'h5
`define JTC_INS_DBG_ISC 4'h8
`define JTC_INS_DBG_BPC 4'h9
`define JTC_INS_DBG_COMM 4'ha
`define JTC_INS_DBG_CTRL 4'hb
`define JTC_INS_BYPASS 4'hf

// data register lengths
`define JTC_ID_W 32
`define JTC_BSCAN_W 16
`define JTC_PROG_W 16
`define JTC_ISC_W 16
`define JTC_BPC_W 16

// synchronised inputs besides the boundary pins: tck, tms, tdi, fuse, disable, debug enable
`define JTC_CTRL_SYNC_W 6

// consecutive tms-high edges that force test-logic-reset
`define JTC_TLR_ONES 3'h5

`endif

// ===== jtc_pkg.sv
// types of the test access port: controller states, register selects, pin and strobe bundles
// assumes jtc_regs.svh is on the include path
`include "jtc_regs.svh"

package jtc_pkg;

   // sixteen controller states
   typedef enum logic [3:0] {
      st_tlr      = 4'h0,
      st_rti      = 4'h1,
      st_sel_dr   = 4'h2,
      st_cap_dr   = 4'h3,
      st_shift_dr = 4'h4,
      st_exit1_dr = 4'h5,
      st_pause_dr = 4'h6,
      st_exit2_dr = 4'h7,
      st_upd_dr   = 4'h8,
      st_sel_ir   = 4'h9,
      st_cap_ir   = 4'ha,
      st_shift_ir = 4'hb,
      st_exit1_ir = 4'hc,
      st_pause_ir = 4'hd,
      st_exit2_ir = 4'he,
      st_upd_ir   = 4'hf
   } jtc_state_t;

   // data register placed between tdi and tdo
   typedef enum logic [2:0] {
      dr_bypass = 3'h0,
      dr_idcode = 3'h1,
      dr_bscan  = 3'h2,
      dr_prog   = 3'h3,
      dr_isc    = 3'h4,
      dr_bpc    = 3'h5
   } jtc_dr_t;

   // test pins toward the device
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } jtc_pins_t;

   // per-register action strobes, one core cycle each
   typedef struct packed {
      logic capture;
      logic shift;
      logic update;
   } jtc_strobe_t;

endpackage : jtc_pkg

// ===== jtc_sync.sv
// two-stage synchroniser for a bundle of asynchronous levels
// assumes each bit is a slow level or a clock far below the core clock
`timescale 1ns/1ps

module jtc_sync #(
   parameter int W = 1
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   genvar g;
   generate
      for (g = 0; g < W; g = g + 1)
      begin : g_bit
         logic meta_reg;
         // first stage feeds only the second
         always_ff @(posedge i_core_clk or negedge i_rst_n)
         begin
            if (!i_rst_n)
            begin
               meta_reg <= 1'b0;
               o_sync[g] <= 1'b0;
            end
            else
            begin
               meta_reg <= i_async[g];
               o_sync[g] <= meta_reg;
            end
         end
      end
   endgenerate

endmodule : jtc_sync

// ===== jtc_data_reg.sv
// one data register: parallel capture, lsb-first serial shift, latched parallel output
// assumes strobes are single core-cycle pulses from the controller
`timescale 1ns/1ps

module jtc_data_reg #(
   parameter int W = 16
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire jtc_pkg::jtc_strobe_t i_strobe,
   input wire logic i_tdi,
   input wire logic [W-1:0] i_par_in,
   output logic [W-1:0] o_par_out,
   output logic o_tdo
);

   logic [W-1:0] shift_reg;

   // capture parallel inputs, then shift toward bit 0
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         shift_reg <= '0;
      else if (i_strobe.capture)
         shift_reg <= i_par_in;
      else if (i_strobe.shift)
         shift_reg <= {i_tdi, shift_reg[W-1:1]};
   end

   assign o_tdo = shift_reg[0];

   // latched output moves only on update
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_par_out <= '0;
      else if (i_strobe.update)
         o_par_out <= shift_reg;
   end

   a_capture_loads_inputs:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_strobe.capture |=> shift_reg == $past(i_par_in))
      else $error("capture did not load parallel inputs");

   a_output_update_only:
   assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      !i_strobe.update |=> $stable(o_par_out))
      else $error("parallel output moved outside update");

endmodule : jtc_data_reg

// ===== jtc_tester_model.sv
// far-side tester: makes tck, drives tms and tdi, reads tdo and its enable, watches and pulls system reset
// assumes tasks are called one at a time just after a core edge; tck stands low between calls
`timescale 1ns/1ps

module jtc_tester_model (
   input wire logic i_core_clk,
   input wire logic i_tdo,
   input wire logic i_tdo_oe,
   input wire logic i_sys_rst_n,
   output logic o_rst_pull,
   output jtc_pkg::jtc_pins_t o_pins
);
   // idle levels: clock low, mode high as the pull-up would leave it, reset line let go
   initial
   begin
      o_pins = 3'b010;
      o_rst_pull = 1'b0;
   end

   // one tck period of 8 core cycles; tdo read late in the high phase, where it stands
   task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe);
      o_pins.tms = tms;
      o_pins.tdi = tdi;
      repeat (4) @(posedge i_core_clk);
      #2 o_pins.tck = 1'b1;
      repeat (4) @(posedge i_core_clk);
      #2 tdo = i_tdo;
      oe = i_tdo_oe;
      o_pins.tck = 1'b0;
   endtask : tick

   // walk the controller: bit i of seq is the tms level on rise i
   task automatic nav(input logic [7:0] seq, input int n);
      logic d;
      logic e;
      for (int i = 0; i < n; i++)
      begin
         tick(seq[i], ~o_pins.tdi, d, e);
      end
   endtask : nav

   // shift n bits lsb first; tms high only on the last bit, which leaves the shift state
   task automatic scan(input logic [31:0] din, input int n, output logic [31:0] dout, output logic oe_all);
      logic e;
      dout = '0;
      oe_all = 1'b1;
      for (int i = 0; i < n; i++)
      begin
         tick(i == n - 1, din[i], dout[i], e);
         oe_all &= e;
      end
   endtask : scan

   // open-collector pull of the system reset for n core cycles; reports the level watched meanwhile
   task automatic pull_reset(input int n, output logic seen);
      o_rst_pull = 1'b1;
      repeat (n) @(posedge i_core_clk);
      seen = i_sys_rst_n;
      #2 o_rst_pull = 1'b0;
   endtask : pull_reset
endmodule : jtc_tester_model

// ===== tb_jtag_tap_controller.sv
// self-checking bench of the test access port cycling all nine instruction codes with random data
// assumes jtc_pkg, jtc_tap and jtc_tester_model are compiled first
`timescale 1ns/1ps

module tb_jtag_tap_controller;
   localparam logic [31:0] id_val = 32'h0bad_c0de; // arbitrary identity value
   localparam logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb, 4'hf};
   logic core_clk;
   logic por_n;
   logic rst_pull;
   logic rst_n;
   jtc_pkg::jtc_pins_t pins;
   logic fuse;
   logic dis;
   logic ocd;
   logic [15:0] bscan_in;
   logic [15:0] prog_in;
   logic [15:0] isc_in;
   logic [15:0] bpc_in;
   logic tdo;
   logic tdo_oe;
   logic pullup_en;
   logic port_mode;
   logic run_idle;
   logic extest;
   logic [3:0] instr;
   logic [15:0] bscan_out;
   logic [15:0] prog_out;
   logic [15:0] isc_out;
   logic [15:0] bpc_out;
   logic [3:0] cur_instr;
   int error_cnt = 0;
   int total_checks = 0;
   int cycles = 0;
   int seed = 32'hfc202cc2;

   // open-collector reset line: power-on source and the tester's pull
   assign rst_n = por_n & ~rst_pull;

   jtc_tap #(.ID_CODE(id_val)) dut (
      .i_core_clk(core_clk), .i_rst_n(rst_n), .i_pins(pins), .i_test_port_enable_fuse(fuse),
      .i_test_port_disable_bit(dis), .i_ocd_enable(ocd), .i_bscan_in(bscan_in), .i_prog_in(prog_in),
      .i_isc_in(isc_in), .i_bpc_in(bpc_in), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_pullup_en(pullup_en),
      .o_port_mode(port_mode), .o_run_idle(run_idle), .o_extest(extest), .o_instr(instr),
      .o_bscan_out(bscan_out), .o_prog_out(prog_out), .o_isc_out(isc_out), .o_bpc_out(bpc_out));

   jtc_tester_model tester (.i_core_clk(core_clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .i_sys_rst_n(rst_n),
      .o_rst_pull(rst_pull), .o_pins(pins));

   // core clock, 40 ns
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   // hang guard
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         error_cnt++;
         $display("MISMATCH %0t run did not finish", $time);
         results();
      end
   end

   task automatic results();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   task automatic chk_word(input logic [63:0] got, input logic [63:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_word

   task automatic chk_flag(input logic got, input logic exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask : chk_flag

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask : settle

   // true when the code leaves the one-bit bypass path selected
   function automatic logic is_byp(input logic [3:0] code, input logic dbg);
      return !(code inside {4'h0, 4'h1, 4'h2, 4'h5}) && !(dbg && code inside {4'h8, 4'h9});
   endfunction : is_byp

   // captured value seen on tdo for a scan of din
   function automatic logic [31:0] dr_exp(input logic [3:0] code, input logic dbg, input logic [31:0] din);
      if (is_byp(code, dbg))
         return {15'h0, din[15:0], 1'b0};
      case (code)
         4'h1: return id_val;
         4'h5: return {16'h0, prog_in};
         4'h8: return {16'h0, isc_in};
         4'h9: return {16'h0, bpc_in};
         default: return {16'h0, bscan_in};
      endcase
   endfunction : dr_exp

   // latched outputs after update-dr
   function automatic logic [63:0] outs_exp(input logic [63:0] old, input logic [3:0] code, input logic dbg,
                                            input logic [15:0] d);
      logic [63:0] r;
      r = old;
      if (code == 4'h0 || code == 4'h2)
         r[63:48] = d;
      if (code == 4'h5)
         r[47:32] = d;
      if (dbg && code == 4'h8)
         r[31:16] = d;
      if (dbg && code == 4'h9)
         r[15:0] = d;
      return r;
   endfunction : outs_exp

   // instruction scan from run-test/idle, ending in exit1-ir
   task automatic load_ir(input logic [3:0] code);
      logic [31:0] dout;
      logic oe_all;
      tester.nav(8'h03, 4);
      tester.scan({28'h0, code}, 4, dout, oe_all);
      chk_word(dout, 64'h1, "ir capture");
      chk_flag(oe_all, 1'b1, "oe in shift-ir");
      chk_word(instr, cur_instr, "instr before update");
   endtask : load_ir

   // main sequence
   initial
   begin : main
      logic [31:0] dout;
      logic [31:0] din;
      logic oe_all;
      logic [63:0] snap;
      logic [3:0] code;
      int n;
      por_n = 1'b0;
      fuse = 1'b1;
      dis = 1'b0;
      ocd = 1'b0;
      {bscan_in, prog_in, isc_in, bpc_in} = '0;
      cur_instr = 4'h1;
      settle(12);
      por_n = 1'b1;
      settle(10);
      chk_word(instr, 4'h1, "instr after reset");
      chk_flag(tdo_oe, 1'b0, "oe after reset");
      chk_flag(pullup_en, 1'b1, "pullup");
      chk_flag(port_mode, 1'b0, "port mode");
      tester.nav(8'h00, 1);
      settle(4);
      chk_flag(run_idle, 1'b1, "idle");
      for (int k = 0; k < 27; k++)
      begin
         code = codes[k % 9];
         ocd = (k < 9) ? 1'b1 : (k < 18) ? 1'b0 : 1'($random(seed)); // debug on, off, then random
         {bscan_in, prog_in} = {$random(seed)};
         {isc_in, bpc_in} = {$random(seed)};
         settle(4);
         load_ir(code);
         if (k % 2 == 1)
            tester.nav(8'h03, 4);
         else
         begin
            tester.nav(8'h01, 2);
            tester.nav(8'h01, 3);
         end
         cur_instr = code;
         chk_word(instr, code, "instr after update");
         chk_flag(extest, code == 4'h0, "extest");
         snap = {bscan_out, prog_out, isc_out, bpc_out};
         din = $random(seed);
         n = is_byp(code, ocd) ? 17 : (code == 4'h1 ? 32 : 16);
         tester.scan(din, n, dout, oe_all);
         chk_word(dout, dr_exp(code, ocd, din), "dr capture");
         chk_flag(oe_all, 1'b1, "oe in shift-dr");
         chk_word({bscan_out, prog_out, isc_out, bpc_out}, snap, "outs before update");
         tester.nav(8'h01, 2);
         chk_word({bscan_out, prog_out, isc_out, bpc_out}, outs_exp(snap, code, ocd, din[15:0]), "outs");
         settle(8);
         chk_flag(tdo_oe, 1'b0, "oe after shift");
      end
      // pause and exit2 leave the instruction alone until update-ir
      load_ir(4'h2);
      tester.nav(8'h04, 3);
      chk_word(instr, cur_instr, "instr in pause");
      tester.nav(8'h01, 2);
      chk_word(instr, 4'h2, "instr after pause");
      // five tms-high periods from shift-ir reach test-logic-reset
      tester.nav(8'h03, 4);
      tester.nav(8'h1f, 5);
      settle(8);
      chk_word(instr, 4'h1, "instr after tms reset");
      chk_flag(tdo_oe, 1'b0, "oe after tms reset");
      // disabled port ignores tck
      dis = 1'b1;
      settle(6);
      chk_flag(port_mode, 1'b1, "port mode disabled");
      chk_flag(pullup_en, 1'b0, "pullup disabled");
      tester.nav(8'h06, 5);
      tester.scan(32'h5, 4, dout, oe_all);
      tester.nav(8'h01, 2);
      chk_flag(oe_all, 1'b0, "oe disabled");
      chk_word(instr, 4'h1, "instr disabled");
      dis = 1'b0;
      fuse = 1'b0;
      settle(6);
      chk_flag(port_mode, 1'b1, "port mode fuse low");
      fuse = 1'b1;
      settle(6);
      chk_flag(port_mode, 1'b0, "port mode enabled");
      // tester pulls the system reset in mid shift-dr; test logic returns to reset
      cur_instr = 4'h1;
      tester.nav(8'h00, 1);
      load_ir(4'h0);
      tester.nav(8'h03, 4);
      tester.pull_reset(4, oe_all);
      chk_flag(oe_all, 1'b0, "reset line pulled");
      chk_word(instr, 4'h1, "instr after system reset");
      chk_flag(tdo_oe, 1'b0, "oe after system reset");
      chk_flag(extest, 1'b0, "extest after system reset");
      settle(10);
      chk_flag(pullup_en, 1'b1, "pullup after system reset");
      results();
   end : main
endmodule : tb_jtag_tap_controller
